// [dmi_pkg.sv]
/*
  Shared constants and carrier types for the DDR3 power-up and
  mode-register sequencer model. Assumes a JEDEC style command bus
  sampled on the rising edge of the link clock.
*/
package dmi_pkg;

  localparam int unsigned DMI_BA_W = 3;
  localparam int unsigned DMI_ADDR_W = 16;
  localparam int unsigned DMI_MR_W = 16;
  localparam int unsigned DMI_MR_SEL_W = 2;
  localparam int unsigned DMI_CNT_W = 12;

  // DLL lock time in link cycles
  localparam int unsigned DMI_TDLLK_CYC = 512;
  // Default ZQ init and mode update times in link cycles
  localparam int unsigned DMI_TZQINIT_CYC = 512;
  localparam int unsigned DMI_TMOD_CYC = 12;

  // Mode register indices as carried on the bank address
  localparam logic [1:0] DMI_MR0 = 2'h0;
  localparam logic [1:0] DMI_MR1 = 2'h1;
  localparam logic [1:0] DMI_MR2 = 2'h2;
  localparam logic [1:0] DMI_MR3 = 2'h3;

  // Field positions
  localparam int unsigned DMI_MR0_DLL_RST_BIT = 8;
  localparam int unsigned DMI_MR1_RTT_B0 = 2;
  localparam int unsigned DMI_MR1_RTT_B1 = 6;
  localparam int unsigned DMI_MR1_RTT_B2 = 9;
  localparam int unsigned DMI_ZQ_LONG_BIT = 10;

  localparam logic [DMI_MR_W-1:0] DMI_MR_RST_VAL = 16'h0000;

  // Command bus as seen at the device balls
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic odt;
    logic [DMI_BA_W-1:0] ba;
    logic [DMI_ADDR_W-1:0] addr;
  } dmi_cmd_s;

  // Status produced by the device core
  typedef struct packed {
    logic cke_seen;
    logic dll_locked;
    logic zq_done;
    logic mod_ready;
    logic rtt_on;
  } dmi_stat_s;

  typedef enum logic [2:0] {
    DMI_ST_RESET = 3'b001,
    DMI_ST_CKE_WAIT = 3'b010,
    DMI_ST_ACTIVE = 3'b100
  } dmi_state_e;

endpackage : dmi_pkg

// [dmi_mode_regs.sv]
/*
  Four-entry mode register store with one write port and a registered
  read port. Assumes writes and clears come from the link clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module dmi_mode_regs (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic i_we,
  input wire logic [dmi_pkg::DMI_MR_SEL_W-1:0] i_wsel,
  input wire logic [dmi_pkg::DMI_MR_W-1:0] i_wdata,
  input wire logic [dmi_pkg::DMI_MR_SEL_W-1:0] i_rsel,
  output logic [dmi_pkg::DMI_MR_W-1:0] o_rdata
);
  import dmi_pkg::*;

  typedef struct packed {
    logic [3:0][DMI_MR_W-1:0] mr;
    logic [DMI_MR_W-1:0] rd;
  } dmi_mr_state_s;

  dmi_mr_state_s s_q;
  dmi_mr_state_s s_d;

  always_comb begin
    s_d = s_q;
    if (i_clr) begin
      s_d.mr = {4{DMI_MR_RST_VAL}};
    end else if (i_we) begin
      s_d.mr[i_wsel] = i_wdata;
    end
    s_d.rd = s_q.mr[i_rsel];
  end

  always_ff @(posedge i_clk) begin
    s_q <= s_d;
  end

  assign o_rdata = s_q.rd;

endmodule : dmi_mode_regs

`default_nettype wire

// [dmi_init_seq.sv]
/*
  Device side of DDR3 power-up, mode-register programming and DLL/ZQ
  bring-up. The command bus is sampled on the controller's clock; status
  is carried into the system clock domain through two-flop synchronisers.
  Assumes the controller keeps its own sequencing duties.
*/
`timescale 1ns/10ps
`default_nettype none

module dmi_init_seq #(
  parameter int unsigned TDLLK_CYC = dmi_pkg::DMI_TDLLK_CYC,
  parameter int unsigned TZQINIT_CYC = dmi_pkg::DMI_TZQINIT_CYC,
  parameter int unsigned TMOD_CYC = dmi_pkg::DMI_TMOD_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ck,
  input wire logic i_reset_n,
  input wire dmi_pkg::dmi_cmd_s i_cmd,
  output logic o_dq_out_en,
  output logic o_rtt_en,
  output logic o_dll_locked,
  output logic o_zq_done,
  output logic o_mod_ready,
  output logic o_init_done,
  output logic o_in_reset
);
  import dmi_pkg::*;

  localparam logic [DMI_CNT_W-1:0] TDLLK_LD = DMI_CNT_W'(TDLLK_CYC);
  localparam logic [DMI_CNT_W-1:0] TZQ_LD = DMI_CNT_W'(TZQINIT_CYC);
  localparam logic [DMI_CNT_W-1:0] TMOD_LD = DMI_CNT_W'(TMOD_CYC);
  localparam logic [DMI_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [DMI_CNT_W-1:0] CNT_ONE = DMI_CNT_W'(1);

  function automatic logic [DMI_CNT_W-1:0] cnt_dec(input logic [DMI_CNT_W-1:0] c);
    cnt_dec = (c == CNT_ZERO) ? CNT_ZERO : c - CNT_ONE;
  endfunction : cnt_dec

  // Link clock domain: command decode, mode registers, DLL and ZQ timers

  typedef struct packed {
    logic rst_m;
    logic rst_s;
    dmi_state_e st;
    logic [DMI_CNT_W-1:0] dll_cnt;
    logic dll_run;
    logic dll_ok;
    logic [DMI_CNT_W-1:0] zq_cnt;
    logic zq_run;
    logic zq_ok;
    logic [DMI_CNT_W-1:0] mod_cnt;
    logic rtt_on;
    logic cke_seen;
    logic mod_idle;
  } dmi_link_s;

  dmi_link_s l_q;
  dmi_link_s l_d;
  logic mr_we;
  logic [DMI_MR_SEL_W-1:0] mr_wsel;
  logic [DMI_MR_W-1:0] mr_wdata;
  logic [DMI_MR_W-1:0] mr1_rd;
  logic cmd_mrs;
  logic cmd_zqcl;
  logic link_rst;
  logic rtt_cfg;

  assign link_rst = !l_q.rst_s;
  // Commands count only while the chip select is active and CKE is high
  assign cmd_mrs = i_cmd.cke && !i_cmd.cs_n && !i_cmd.ras_n && !i_cmd.cas_n && !i_cmd.we_n;
  assign cmd_zqcl = i_cmd.cke && !i_cmd.cs_n && i_cmd.ras_n && i_cmd.cas_n && !i_cmd.we_n
                    && i_cmd.addr[DMI_ZQ_LONG_BIT];
  assign rtt_cfg = mr1_rd[DMI_MR1_RTT_B0] | mr1_rd[DMI_MR1_RTT_B1] | mr1_rd[DMI_MR1_RTT_B2];

  always_comb begin
    l_d = l_q;
    mr_we = 1'b0;
    mr_wsel = i_cmd.ba[DMI_MR_SEL_W-1:0];
    mr_wdata = i_cmd.addr[DMI_MR_W-1:0];
    l_d.rst_m = i_reset_n;
    l_d.rst_s = l_q.rst_m;
    l_d.dll_cnt = cnt_dec(l_q.dll_cnt);
    l_d.zq_cnt = cnt_dec(l_q.zq_cnt);
    l_d.mod_cnt = cnt_dec(l_q.mod_cnt);
    if (l_q.dll_run && l_q.dll_cnt == CNT_ONE) begin
      l_d.dll_run = 1'b0;
      l_d.dll_ok = 1'b1;
    end
    if (l_q.zq_run && l_q.zq_cnt == CNT_ONE) begin
      l_d.zq_run = 1'b0;
      l_d.zq_ok = 1'b1;
    end
    case (l_q.st)
      DMI_ST_RESET: begin
        l_d.st = DMI_ST_CKE_WAIT;
      end
      DMI_ST_CKE_WAIT: begin
        if (i_cmd.cke) begin
          l_d.st = DMI_ST_ACTIVE;
        end
      end
      DMI_ST_ACTIVE: begin
        // Whole-register write; DLL reset bit never stored
        if (cmd_mrs) begin
          mr_we = 1'b1;
          l_d.mod_cnt = TMOD_LD;
          if (mr_wsel == DMI_MR0) begin
            mr_wdata[DMI_MR0_DLL_RST_BIT] = 1'b0;
            if (i_cmd.addr[DMI_MR0_DLL_RST_BIT]) begin
              l_d.dll_run = 1'b1;
              l_d.dll_ok = 1'b0;
              l_d.dll_cnt = TDLLK_LD;
            end
          end
        end else if (cmd_zqcl) begin
          l_d.zq_run = 1'b1;
          l_d.zq_ok = 1'b0;
          l_d.zq_cnt = TZQ_LD;
        end
      end
      default: begin
        l_d.st = DMI_ST_RESET;
      end
    endcase
    // Termination follows ODT only once configured and past tMOD
    l_d.rtt_on = (l_q.st == DMI_ST_ACTIVE) && i_cmd.odt && rtt_cfg
                 && (l_q.mod_cnt == CNT_ZERO) && !cmd_mrs;
    if (link_rst) begin
      l_d.st = DMI_ST_RESET;
      l_d.dll_cnt = CNT_ZERO;
      l_d.dll_run = 1'b0;
      l_d.dll_ok = 1'b0;
      l_d.zq_cnt = CNT_ZERO;
      l_d.zq_run = 1'b0;
      l_d.zq_ok = 1'b0;
      l_d.mod_cnt = CNT_ZERO;
      l_d.rtt_on = 1'b0;
      mr_we = 1'b0;
    end
    // Flopped so the crossing never sees decode glitches
    l_d.cke_seen = (l_d.st == DMI_ST_ACTIVE);
    l_d.mod_idle = (l_d.mod_cnt == CNT_ZERO);
  end

  always_ff @(posedge i_ck) begin
    l_q <= l_d;
  end

  // Array is cleared on link reset, so settings written before reset cannot survive it
  dmi_mode_regs u_mode_regs (
    .i_clk(i_ck),
    .i_clr(link_rst),
    .i_we(mr_we),
    .i_wsel(mr_wsel),
    .i_wdata(mr_wdata),
    .i_rsel(DMI_MR1),
    .o_rdata(mr1_rd)
  );

  // System clock domain: level synchronisers and registered outputs

  dmi_stat_s link_stat;
  assign link_stat = '{cke_seen: l_q.cke_seen, dll_locked: l_q.dll_ok,
                       zq_done: l_q.zq_ok, mod_ready: l_q.mod_idle,
                       rtt_on: l_q.rtt_on};

  typedef struct packed {
    logic rst_m;
    logic rst_s;
    dmi_stat_s stat_m;
    dmi_stat_s stat_s;
    logic dq_out_en;
    logic rtt_en;
    logic dll_locked;
    logic zq_done;
    logic mod_ready;
    logic init_done;
    logic in_reset;
  } dmi_sys_s;

  dmi_sys_s s_q;
  dmi_sys_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.rst_m = i_reset_n;
    s_d.rst_s = s_q.rst_m;
    s_d.stat_m = link_stat;
    s_d.stat_s = s_q.stat_m;
    s_d.in_reset = !s_q.rst_s;
    s_d.dll_locked = s_q.rst_s && s_q.stat_s.dll_locked;
    s_d.zq_done = s_q.rst_s && s_q.stat_s.zq_done;
    s_d.mod_ready = s_q.rst_s && s_q.stat_s.cke_seen && s_q.stat_s.mod_ready;
    s_d.init_done = s_q.rst_s && s_q.stat_s.dll_locked && s_q.stat_s.zq_done;
    s_d.rtt_en = s_q.rst_s && s_q.stat_s.cke_seen && s_q.stat_s.rtt_on;
    // Drivers stay off through reset and until the core is ready
    s_d.dq_out_en = s_q.rst_s && s_q.stat_s.dll_locked && s_q.stat_s.zq_done;
    if (i_rst) begin
      s_d = '0;
      s_d.in_reset = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    s_q <= s_d;
  end

  assign o_dq_out_en = s_q.dq_out_en;
  assign o_rtt_en = s_q.rtt_en;
  assign o_dll_locked = s_q.dll_locked;
  assign o_zq_done = s_q.zq_done;
  assign o_mod_ready = s_q.mod_ready;
  assign o_init_done = s_q.init_done;
  assign o_in_reset = s_q.in_reset;

endmodule : dmi_init_seq

`default_nettype wire

// [dmi_init_seq_assertions.sv]
/* Port checker for dmi_init_seq.
   Assumes the bind below reaches every instance. */
`timescale 1ns/10ps
`default_nettype none
module dmi_init_seq_assertions #(
  parameter int unsigned TDLLK_CYC = 512,
  parameter int unsigned TZQINIT_CYC = 512,
  parameter int unsigned TMOD_CYC = 12
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ck,
  input wire logic i_reset_n,
  input wire dmi_pkg::dmi_cmd_s i_cmd,
  input wire logic o_dq_out_en,
  input wire logic o_rtt_en,
  input wire logic o_dll_locked,
  input wire logic o_zq_done,
  input wire logic o_mod_ready,
  input wire logic o_init_done,
  input wire logic o_in_reset
);
  import dmi_pkg::*;
  logic mrs;
  logic zqcl;
  logic [11:0] dll_q;
  logic [11:0] zq_q;
  logic [11:0] mod_q;
  assign mrs = i_cmd.cke & ~i_cmd.cs_n & ~i_cmd.ras_n & ~i_cmd.cas_n & ~i_cmd.we_n;
  assign zqcl = i_cmd.cke & ~i_cmd.cs_n & i_cmd.ras_n & i_cmd.cas_n & ~i_cmd.we_n & i_cmd.addr[10];
  // Saturating link-cycle ages; guards below skip the sync lag
  always_ff @(posedge i_ck) begin
    dll_q <= (!i_reset_n || (mrs && i_cmd.ba[1:0] == DMI_MR0 && i_cmd.addr[8])) ? 12'h000 :
      dll_q + {11'h000, dll_q != 12'hFFF};
    zq_q <= (!i_reset_n || zqcl) ? 12'h000 : zq_q + {11'h000, zq_q != 12'hFFF};
    mod_q <= !i_reset_n ? 12'hFFF : mrs ? 12'h000 : mod_q + {11'h000, mod_q != 12'hFFF};
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  chk_dq_hiz: assert property (o_in_reset [*2] |-> !o_dq_out_en)
    else $error("data drivers on in reset");
  chk_rtt_hiz: assert property (o_in_reset [*2] |-> !o_rtt_en)
    else $error("termination on in reset");
  chk_dll_age: assert property (o_dll_locked && dll_q > 12'h004 |-> dll_q >= TDLLK_CYC)
    else $error("dll lock before lock time");
  chk_dll_prompt: assert property ($rose(o_dll_locked) |-> dll_q <= TDLLK_CYC + 6)
    else $error("dll lock late");
  chk_zq_age: assert property (o_zq_done && zq_q > 12'h004 |-> zq_q >= TZQINIT_CYC)
    else $error("zq done before calibration time");
  chk_mod_wait: assert property (o_mod_ready && mod_q > 12'h004 |-> mod_q >= TMOD_CYC)
    else $error("mode ready inside mode update time");
  chk_init_pair: assert property ((!(o_dll_locked && o_zq_done)) [*3] |-> !o_init_done)
    else $error("init done without lock and calibration");
  chk_rst_clear: assert property (disable iff (1'b0) i_rst |=> o_in_reset && !o_dll_locked)
    else $error("reset did not clear status");
  cov_init: cover property ($rose(o_init_done));
  cov_rtt: cover property ($rose(o_rtt_en));
  cov_relock: cover property ($fell(o_dll_locked));
endmodule : dmi_init_seq_assertions
bind dmi_init_seq dmi_init_seq_assertions #(.TDLLK_CYC(TDLLK_CYC), .TZQINIT_CYC(TZQINIT_CYC),
  .TMOD_CYC(TMOD_CYC)) u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ck(i_ck),
  .i_reset_n(i_reset_n), .i_cmd(i_cmd), .o_dq_out_en(o_dq_out_en), .o_rtt_en(o_rtt_en),
  .o_dll_locked(o_dll_locked), .o_zq_done(o_zq_done), .o_mod_ready(o_mod_ready),
  .o_init_done(o_init_done), .o_in_reset(o_in_reset));
`default_nettype wire

// [dmi_ctrl_model.sv]
/* Memory controller model driving reset, CKE, ODT and commands.
   Assumes the link clock comes from the bench. */
`timescale 1ns/10ps
`default_nettype none
module dmi_ctrl_model #(
  parameter int unsigned T_RST_CK = 3125,
  parameter int unsigned T_CKE_CK = 7812
) (
  input wire logic i_ck,
  output logic o_reset_n,
  output dmi_pkg::dmi_cmd_s o_cmd
);
  import dmi_pkg::*;
  initial begin
    o_reset_n = 1'b0;
    o_cmd = '0;
  end
  task automatic nop(input int unsigned n);
    repeat (n) begin
      @(negedge i_ck);
      o_cmd.cs_n = 1'b1;
      o_cmd.addr = 16'($urandom); // Deselected lines wobble
    end
  endtask : nop
  task automatic issue(input logic [2:0] rcw, input logic [2:0] ba, input logic [15:0] a);
    @(negedge i_ck);
    {o_cmd.cs_n, o_cmd.ras_n, o_cmd.cas_n, o_cmd.we_n} = {1'b0, rcw};
    o_cmd.ba = ba;
    o_cmd.addr = a;
    nop(16);
  endtask : issue
  task automatic odt(input logic v);
    @(negedge i_ck);
    o_cmd.odt = v;
  endtask : odt
  task automatic mr0_zq();
    issue(3'b000, 3'b000, 16'($urandom) | 16'h0100);
    issue(3'b110, 3'b000, 16'h0400);
  endtask : mr0_zq
  task automatic hold_reset();
    @(negedge i_ck);
    o_reset_n = 1'b0;
    nop(8);
  endtask : hold_reset
  task automatic release_reset();
    @(negedge i_ck);
    o_cmd.cke = 1'b0;
    nop(T_RST_CK);
    o_reset_n = 1'b1;
    nop(T_CKE_CK);
    o_cmd.odt = 1'b0;
    nop(1);
    o_cmd.cke = 1'b1;
    nop(8);
  endtask : release_reset
  task automatic power_up(input logic [15:0] mr1);
    @(negedge i_ck);
    o_reset_n = 1'b0;
    release_reset();
    issue(3'b000, 3'b010, 16'($urandom));
    issue(3'b000, 3'b011, 16'($urandom));
    issue(3'b000, 3'b001, mr1);
    mr0_zq();
  endtask : power_up
endmodule : dmi_ctrl_model
`default_nettype wire

// [dmi_init_seq_bench.sv]
/* Self-checking bench for dmi_init_seq.
   Assumes dmi_ctrl_model plays the controller on the link. */
`timescale 1ns/10ps
`default_nettype none
module dmi_init_seq_bench;
  import dmi_pkg::*;
  logic i_clk_sys, i_ck, i_rst, reset_n, dq, rtt, dll, zq, modr, done, inrst, done_q;
  logic [3:0] mon;
  dmi_cmd_s cmd;
  int err_count = 0;
  int tests_run = 0;
  logic [1:0] exp_q[$];
  assign mon = {inrst, dll, rtt, done};
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    i_ck = 1'b0;
    #7;
    forever #32 i_ck = ~i_ck;
  end
  dmi_ctrl_model u_ctl (.i_ck(i_ck), .o_reset_n(reset_n), .o_cmd(cmd));
  dmi_init_seq #(.TZQINIT_CYC(8)) i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ck(i_ck),
    .i_reset_n(reset_n), .i_cmd(cmd), .o_dq_out_en(dq), .o_rtt_en(rtt), .o_dll_locked(dll),
    .o_zq_done(zq), .o_mod_ready(modr), .o_init_done(done), .o_in_reset(inrst));
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %b expected %b", $time, got, exp);
    end
  endtask : check
  task automatic wait_for(input int s, input logic v);
    int n;
    n = 0;
    while (mon[s] !== v && n < 4000) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n == 4000) begin
      err_count++;
      $display("BAD %0t wait timed out", $time);
      stop_test();
    end
  endtask : wait_for
  // Each rise of init done consumes one note
  always @(negedge i_clk_sys) begin
    if (done === 1'b1 && done_q !== 1'b1) begin
      if (exp_q.size() == 0)
        check(2'b00, 2'b11);
      else
        check({dll, zq}, exp_q.pop_front());
    end
    done_q <= done;
  end
  initial begin
    i_rst = 1'b1;
    void'($urandom(32'hE82DC2CE));
    repeat (8) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk_sys);
    check({dq, rtt}, 2'b00);
    check({inrst, dll}, 2'b10);
    exp_q.push_back(2'b11);
    u_ctl.power_up((16'($urandom) & 16'hEF7E) | 16'h0004);
    check({rtt, dq}, 2'b00);
    wait_for(0, 1'b1);
    repeat (4) @(negedge i_clk_sys);
    check({dq, modr}, 2'b11);
    fork
      u_ctl.issue(3'b000, 3'b011, 16'($urandom));
      begin
        repeat (15) @(negedge i_clk_sys);
        check({modr, dll}, 2'b01);
      end
    join
    u_ctl.odt(1'b1);
    wait_for(1, 1'b1);
    u_ctl.odt(1'b0);
    exp_q.push_back(2'b11);
    fork
      u_ctl.mr0_zq();
      wait_for(2, 1'b0);
    join
    wait_for(0, 1'b1);
    u_ctl.hold_reset();
    wait_for(3, 1'b1);
    repeat (12) @(negedge i_clk_sys);
    check({dq, rtt}, 2'b00);
    check({dll, zq}, 2'b00);
    // Mode registers must come back cleared, so ODT alone cannot terminate
    u_ctl.release_reset();
    u_ctl.odt(1'b1);
    repeat (20) @(negedge i_clk_sys);
    check({inrst, rtt}, 2'b00);
    check({modr, dll}, 2'b10);
    u_ctl.odt(1'b0);
    check(2'(exp_q.size()), 2'b00);
    stop_test();
  end
endmodule : dmi_init_seq_bench
`default_nettype wire
